// *** verilog/ldfc_regs.v ***
`timescale 1ns/1ns
`include "ldfc_defs.vh"
module ldfc_regs #(
  parameter STEP_CYCLES = `LDFC_STEP_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // serial link pins
  input wire sclk,
  input wire chip_select_n,
  input wire sdi,
  output reg sdo_out,
  output reg sdo_oe_n,
  // device pins and neighbouring logic
  input wire alarm_polarity_pin,
  input wire loop_fault,
  input wire [7:0] high_alarm_level,
  input wire status_read,
  // converter and fault pin
  output reg [15:0] output_code,
  output reg fault_pin_out,
  output reg fault_pin_oe_n,
  output reg link_timeout
);

  // cut on purpose: one step fits the 23-bit prescalers
  localparam [31:0] STEP_LAST_W = STEP_CYCLES - 1;
  localparam [31:0] BIT_LAST_W = `LDFC_FRAME_BITS - 1;
  localparam [22:0] STEP_LAST = STEP_LAST_W[22:0];
  localparam [4:0] BIT_LAST = BIT_LAST_W[4:0];

  // synchronised pins
  wire [4:0] pins_s;
  wire sclk_s = pins_s[0];
  wire cs_n_s = pins_s[1];
  wire sdi_s = pins_s[2];
  wire pol_s = pins_s[3];
  wire loop_s = pins_s[4];

  ldfc_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .async_in({loop_fault, alarm_polarity_pin, sdi, chip_select_n, sclk}),
    .sync_out(pins_s)
  );

  // edge detection on synchronised link signals
  reg sclk_d;
  reg cs_n_d;
  wire sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
  wire cs_fall = ~cs_n_s & cs_n_d;
  wire cs_rise = cs_n_s & ~cs_n_d;

  // frame shifter
  reg [23:0] shifter;
  reg [4:0] bit_cnt;
  reg whole_frame;
  reg seen_rise;

  // registers
  reg protect_mode;
  reg [10:0] fault_cfg;
  reg [7:0] low_alarm;

  // staging buffer for protected mode
  reg pend_valid;
  reg [6:0] pend_addr;
  reg [15:0] pend_data;

  // timers and fault state
  reg [22:0] silence_pre;
  reg [3:0] silence_steps;
  reg [22:0] retry_pre;
  reg [3:0] retry_steps;
  reg loop_hold;

  // decoded frame
  wire [7:0] cmd = shifter[23:16];
  wire [15:0] frame_data = shifter[15:0];
  wire frame_done = cs_rise & whole_frame;
  wire is_read = cmd[`LDFC_CMD_READ_BIT];
  wire is_write = frame_done & ~is_read;
  wire is_commit = (cmd[6:0] == `LDFC_ADDR_COMMIT) &&
    (frame_data == `LDFC_COMMIT_KEY);

  // config fields
  wire [2:0] retry_field = fault_cfg[`LDFC_CFG_RETRY_HI:`LDFC_CFG_RETRY_LO];
  wire retry_dis = fault_cfg[`LDFC_CFG_RETRY_DIS];
  wire loop_mask = fault_cfg[`LDFC_CFG_LOOP_MASK];
  wire pin_dis = fault_cfg[`LDFC_CFG_PIN_DIS];
  wire tout_out_mask = fault_cfg[`LDFC_CFG_TOUT_OUT_MASK];
  wire [2:0] tout_field = fault_cfg[`LDFC_CFG_TOUT_HI:`LDFC_CFG_TOUT_LO];
  wire tout_rep_mask = fault_cfg[`LDFC_CFG_TOUT_REPORT_MASK];

  // interval of (field + 1) steps has elapsed
  function expired;
    input [3:0] steps;
    input [2:0] field;
    begin
      expired = steps > {1'b0, field};
    end
  endfunction

  function is_writable;
    input [6:0] addr;
    begin
      is_writable = (addr == `LDFC_ADDR_MODE) ||
        (addr == `LDFC_ADDR_CODE) || (addr == `LDFC_ADDR_CFG) ||
        (addr == `LDFC_ADDR_LOW);
    end
  endfunction

  // register read mux; unlisted addresses read as zero
  function [15:0] read_word;
    input [6:0] addr;
    input pm;
    input [15:0] code;
    input [10:0] cfg;
    input [7:0] low;
    begin
      case (addr)
        `LDFC_ADDR_MODE: read_word = {15'h0000, pm};
        `LDFC_ADDR_CODE: read_word = code;
        `LDFC_ADDR_CFG: read_word = {5'h00, cfg};
        `LDFC_ADDR_LOW: read_word = {low, `LDFC_LOW_FILL};
        default: read_word = 16'h0000;
      endcase
    end
  endfunction

  // write that reaches a register this cycle
  reg wr_go;
  reg [6:0] wr_addr;
  reg [15:0] wr_data;
  reg [15:0] req_code;

  always @* begin
    wr_go = 1'b0;
    wr_addr = cmd[6:0];
    wr_data = frame_data;
    if (is_write) begin
      if (!protect_mode) begin
        wr_go = is_writable(cmd[6:0]);
      end else if (is_commit && pend_valid) begin
        wr_go = 1'b1;
        wr_addr = pend_addr;
        wr_data = pend_data;
      end
    end
  end

  // link edges and frame shifting
  always @(posedge clk) begin
    if (!reset_n) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      shifter <= 24'h000000;
      bit_cnt <= 5'h00;
      whole_frame <= 1'b0;
      seen_rise <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
      sdo_oe_n <= cs_n_s;
      if (cs_fall) begin
        bit_cnt <= 5'h00;
        whole_frame <= 1'b0;
        seen_rise <= 1'b0;
        sdo_out <= shifter[23];
      end else if (sclk_rise) begin
        shifter <= {shifter[22:0], sdi_s};
        seen_rise <= 1'b1;
        // only a multiple of 24 edges makes a usable frame
        if (bit_cnt == BIT_LAST) begin
          bit_cnt <= 5'h00;
          whole_frame <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
          whole_frame <= 1'b0;
        end
      end else if (sclk_fall && seen_rise) begin
        sdo_out <= shifter[23];
      end else if (frame_done && is_read) begin
        // command byte kept, register contents loaded for next frame
        shifter <= {cmd, read_word(cmd[6:0], protect_mode, output_code,
          fault_cfg, low_alarm)};
      end
    end
  end

  // registers and staging buffer
  always @(posedge clk) begin
    if (!reset_n) begin
      protect_mode <= `LDFC_MODE_RESET;
      fault_cfg <= `LDFC_CFG_RESET;
      low_alarm <= `LDFC_LOW_RESET;
      req_code <= pol_s ? `LDFC_CODE_RESET_HIGH
        : `LDFC_CODE_RESET_LOW;
      pend_valid <= 1'b0;
      pend_addr <= 7'h00;
      pend_data <= 16'h0000;
    end else begin
      if (is_write && protect_mode && is_writable(cmd[6:0])) begin
        pend_valid <= 1'b1;
        pend_addr <= cmd[6:0];
        pend_data <= frame_data;
      end else if (wr_go && protect_mode) begin
        pend_valid <= 1'b0;
      end
      if (wr_go) begin
        case (wr_addr)
          `LDFC_ADDR_MODE: protect_mode <= wr_data[0];
          `LDFC_ADDR_CODE: req_code <= wr_data;
          `LDFC_ADDR_CFG: fault_cfg <= wr_data[10:0];
          `LDFC_ADDR_LOW: begin
            if (wr_data[15:8] <= `LDFC_LOW_MAX) begin
              low_alarm <= wr_data[15:8];
            end
          end
          default: req_code <= req_code;
        endcase
      end
    end
  end

  // link silence timer; any write frame, nop included, restarts it
  always @(posedge clk) begin
    if (!reset_n) begin
      silence_pre <= 23'h000000;
      silence_steps <= 4'h0;
      link_timeout <= 1'b0;
    end else if (is_write) begin
      silence_pre <= 23'h000000;
      silence_steps <= 4'h0;
      link_timeout <= 1'b0;
    end else if (!link_timeout) begin
      if (expired(silence_steps, tout_field)) begin
        link_timeout <= 1'b1;
      end else if (silence_pre == STEP_LAST) begin
        silence_pre <= 23'h000000;
        silence_steps <= silence_steps + 4'h1;
      end else begin
        silence_pre <= silence_pre + 23'h000001;
      end
    end
  end

  // loop fault alarm hold and retry timer
  always @(posedge clk) begin
    if (!reset_n) begin
      loop_hold <= 1'b0;
      retry_pre <= 23'h000000;
      retry_steps <= 4'h0;
    end else if (loop_mask) begin
      loop_hold <= 1'b0;
      retry_pre <= 23'h000000;
      retry_steps <= 4'h0;
    end else if (!loop_hold) begin
      loop_hold <= loop_s;
      retry_pre <= 23'h000000;
      retry_steps <= 4'h0;
    end else if (retry_dis) begin
      // a fault still present re-arms the alarm one clock after the release
      if (status_read) begin
        loop_hold <= 1'b0;
      end
    end else if (expired(retry_steps, retry_field)) begin
      loop_hold <= 1'b0;
    end else if (retry_pre == STEP_LAST) begin
      retry_pre <= 23'h000000;
      retry_steps <= retry_steps + 4'h1;
    end else begin
      retry_pre <= retry_pre + 23'h000001;
    end
  end

  // converter code and fault pin
  wire tout_reported = link_timeout & ~tout_rep_mask;
  wire tout_alarm = tout_reported & ~tout_out_mask;

  always @(posedge clk) begin
    if (!reset_n) begin
      output_code <= pol_s ? `LDFC_CODE_RESET_HIGH : `LDFC_CODE_RESET_LOW;
      fault_pin_out <= 1'b0;
      fault_pin_oe_n <= 1'b1;
    end else begin
      fault_pin_out <= 1'b0;
      fault_pin_oe_n <= ~((loop_s & ~pin_dis) |
        tout_reported);
      if (tout_alarm) begin
        output_code <= pol_s ? {high_alarm_level, `LDFC_LOW_FILL}
          : {low_alarm, `LDFC_LOW_FILL};
      end else if (loop_hold) begin
        output_code <= {low_alarm, `LDFC_LOW_FILL};
      end else begin
        output_code <= req_code;
      end
    end
  end

endmodule

// *** verilog/ldfc_defs.vh ***
`ifndef LDFC_DEFS_VH
`define LDFC_DEFS_VH

// register addresses carried in the command byte
`define LDFC_ADDR_COMMIT 7'h01
`define LDFC_ADDR_NOP 7'h02
`define LDFC_ADDR_MODE 7'h03
`define LDFC_ADDR_CODE 7'h04
`define LDFC_ADDR_CFG 7'h05
`define LDFC_ADDR_LOW 7'h06

// frame layout
`define LDFC_FRAME_BITS 24
`define LDFC_CMD_READ_BIT 7
`define LDFC_COMMIT_KEY 16'h00FF

// reset values
`define LDFC_MODE_RESET 1'b0
`define LDFC_CFG_RESET 11'h102
`define LDFC_LOW_RESET 8'h24
`define LDFC_CODE_RESET_LOW 16'h2400
`define LDFC_CODE_RESET_HIGH 16'hE800

// fault configuration field positions
`define LDFC_CFG_RETRY_HI 10
`define LDFC_CFG_RETRY_LO 8
`define LDFC_CFG_RETRY_DIS 7
`define LDFC_CFG_LOOP_MASK 6
`define LDFC_CFG_PIN_DIS 5
`define LDFC_CFG_TOUT_OUT_MASK 4
`define LDFC_CFG_TOUT_HI 3
`define LDFC_CFG_TOUT_LO 1
`define LDFC_CFG_TOUT_REPORT_MASK 0

// low alarm limits
`define LDFC_LOW_MAX 8'h80
`define LDFC_LOW_FILL 8'h00

// timing: one interval step and the clock rate
`define LDFC_STEP_MS 50
`define LDFC_CLK_MHZ 100
`define LDFC_STEP_CYCLES (`LDFC_STEP_MS * 1000 * `LDFC_CLK_MHZ)

`endif

// *** verilog/ldfc_sync.v ***
`timescale 1ns/1ns
module ldfc_sync #(
  parameter WIDTH = 1
) (
  // clock
  input wire clk,
  // asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage;

  // no reset: the chain must track the pins while reset is held
  always @(posedge clk) begin
    stage <= async_in;
    sync_out <= stage;
  end

endmodule

// *** bench/ldfc_checker.sv ***
`timescale 1ns/1ns
module ldfc_checker #(
  parameter STEP_CYCLES = 20
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // link pins
  input wire sclk,
  input wire chip_select_n,
  input wire sdi,
  input wire sdo_out,
  input wire sdo_oe_n,
  // device pins
  input wire alarm_polarity_pin,
  input wire loop_fault,
  input wire [7:0] high_alarm_level,
  input wire status_read,
  // converter and fault pin
  input wire [15:0] output_code,
  input wire fault_pin_out,
  input wire fault_pin_oe_n,
  input wire link_timeout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_reset_code: assert property (
    $rose(reset_n) |->
      output_code == (alarm_polarity_pin ? 16'hE800 : 16'h2400))
    else $error("reset code wrong");
  chk_reset_quiet: assert property (
    $rose(reset_n) |-> sdo_oe_n && fault_pin_oe_n && !link_timeout)
    else $error("outputs active after reset");
  chk_fault_level: assert property (!fault_pin_out)
    else $error("fault pin driven high");
  chk_sdo_release: assert property (
    chip_select_n [*6] |-> sdo_oe_n)
    else $error("sdo driven while deselected");
  chk_sdo_drive: assert property (
    !sdo_oe_n |-> !chip_select_n || !$past(chip_select_n, 5))
    else $error("sdo driven without a frame");
  chk_fault_cause: assert property (
    $fell(fault_pin_oe_n) |->
      link_timeout || loop_fault || $past(loop_fault, 6))
    else $error("fault pin low without cause");
  chk_timeout_silent: assert property (
    $rose(link_timeout) |-> chip_select_n && $past(chip_select_n, 4))
    else $error("timeout during link traffic");
  chk_timeout_clear: assert property (
    link_timeout && $rose(chip_select_n) |-> ##[2:8] !link_timeout)
    else $error("write did not clear timeout");
endmodule

bind ldfc_regs ldfc_checker #(.STEP_CYCLES(STEP_CYCLES)) ldfc_checker_inst (
  .clk(clk), .reset_n(reset_n), .sclk(sclk),
  .chip_select_n(chip_select_n), .sdi(sdi), .sdo_out(sdo_out),
  .sdo_oe_n(sdo_oe_n), .alarm_polarity_pin(alarm_polarity_pin),
  .loop_fault(loop_fault), .high_alarm_level(high_alarm_level),
  .status_read(status_read), .output_code(output_code),
  .fault_pin_out(fault_pin_out), .fault_pin_oe_n(fault_pin_oe_n),
  .link_timeout(link_timeout));

// *** bench/ldfc_host.sv ***
`timescale 1ns/1ns
module ldfc_host (
  // link pins
  output logic sclk,
  output logic chip_select_n,
  output logic sdi,
  input wire sdo,
  // bits seen on sdo in the last frame
  output logic [23:0] rx
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
    rx = 24'h000000;
  end
  // sclk only runs inside frames; 80 ns phases keep each >= 3 clk
  task automatic xfer(input logic [23:0] tx);
    chip_select_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = tx[i];
      #80 sclk = 1'b1;
      rx = {rx[22:0], sdo};
      #80 sclk = 1'b0;
    end
    #80 chip_select_n = 1'b1;
    // idle data flips so a stale bit is never trusted
    sdi = ~sdi;
    #80;
  endtask
endmodule

// *** bench/test_loop_dac_fault_config_regs.sv ***
`timescale 1ns/1ns
module test_loop_dac_fault_config_regs;
  typedef struct {logic w; logic [23:0] f; logic [15:0] q;} ldfc_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic pol = 1'b0;
  logic loop_fault = 1'b0;
  logic status_read = 1'b0;
  logic [7:0] high_alarm = 8'hE8;
  wire sclk, cs_n, sdi, sdo_out, sdo_oe_n, pin_out, pin_oe_n, tout;
  wire [15:0] code;
  wire [23:0] rx;
  // pulled up while released
  wire sdo = sdo_oe_n ? 1'b1 : sdo_out;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  ldfc_row_t rows [12] = '{
    '{1'b0, 24'h030000, 16'h0000}, '{1'b0, 24'h040000, 16'h2400},
    '{1'b0, 24'h050000, 16'h0102}, '{1'b0, 24'h060000, 16'h2400},
    '{1'b1, 24'h041234, 16'h1234}, '{1'b1, 24'h062A55, 16'h2A00},
    '{1'b1, 24'h068000, 16'h8000}, '{1'b1, 24'h068100, 16'h8000},
    '{1'b1, 24'h05FFFF, 16'h07FF}, '{1'b1, 24'h050102, 16'h0102},
    '{1'b1, 24'h02FFFF, 16'h0000}, '{1'b1, 24'h030000, 16'h0000}};

  always #5 clk = ~clk;

  ldfc_regs #(.STEP_CYCLES(1000)) ldfc_regs_inst (
    .clk(clk), .reset_n(reset_n), .sclk(sclk), .chip_select_n(cs_n),
    .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .alarm_polarity_pin(pol), .loop_fault(loop_fault),
    .high_alarm_level(high_alarm), .status_read(status_read),
    .output_code(code), .fault_pin_out(pin_out),
    .fault_pin_oe_n(pin_oe_n), .link_timeout(tout));

  ldfc_host ldfc_host_inst (.sclk(sclk), .chip_select_n(cs_n),
    .sdi(sdi), .sdo(sdo), .rx(rx));

  task automatic cmp(input string what, input logic [16:0] exp,
                     input logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [23:0] f);
    ldfc_host_inst.xfer(f);
  endtask

  // second frame is a no-operation write that also carries the answer
  task automatic rd(input logic [7:0] a);
    wr({a | 8'h80, 16'h0000});
    wr(24'h020000);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w)
        wr(rows[i].f);
      rd(rows[i].f[23:16]);
      cmp("readback", {1'b0, rows[i].q}, {1'b0, rx[15:0]});
    end
    // silence: low alarm 0x80 must reach the converter
    repeat (2300) @(negedge clk);
    cmp("timeout code", {1'b1, 16'h8000}, {tout, code});
    cmp("timeout pin", 17'h0, {16'h0, pin_oe_n});
    wr(24'h044321);
    cmp("restored", {1'b0, 16'h4321}, {tout, code});
    wr(24'h030001);
    wr(24'h045555);
    wr(24'h046666);
    cmp("staged", {1'b0, 16'h4321}, {1'b0, code});
    wr(24'h0100FF);
    cmp("committed", {1'b0, 16'h6666}, {1'b0, code});
    wr(24'h030000);
    wr(24'h0100FF);
    @(negedge clk) loop_fault = 1'b1;
    repeat (10) @(negedge clk);
    cmp("loop alarm", {1'b0, 16'h8000}, {pin_oe_n, code});
    wr(24'h0501A2);
    cmp("pin disabled", 17'h1, {16'h0, pin_oe_n});
    loop_fault = 1'b0;
    repeat (10) @(negedge clk);
    cmp("held alarm", {1'b0, 16'h8000}, {1'b0, code});
    status_read = 1'b1;
    @(negedge clk) status_read = 1'b0;
    repeat (4) @(negedge clk);
    cmp("status release", {1'b0, 16'h6666}, {1'b0, code});
    pol = 1'b1;
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    cmp("reset code", {1'b0, 16'hE800}, {tout, code});
    // high polarity: timeout picks the high alarm byte
    high_alarm = 8'hC8;
    repeat (2300) @(negedge clk);
    cmp("high alarm", {1'b1, 16'hC800}, {tout, code});
    wr(24'h041111);
    wr(24'h050112);
    repeat (2300) @(negedge clk);
    cmp("tout out masked", {1'b1, 16'h1111}, {tout, code});
    cmp("masked pin", 17'h0, {16'h0, pin_oe_n});
    wr(24'h050103);
    repeat (2300) @(negedge clk);
    cmp("tout unreported", {1'b1, 16'h1111}, {tout, code});
    cmp("unreported pin", 17'h1, {16'h0, pin_oe_n});
    end_sim();
  end
endmodule
